//--- hw/estim_if.sv
`timescale 1ns/1ps
interface estim_if;
  import link_diag_pkg::*;
  logic        step;
  logic        use_est;
  sample_t     last;
  sample_t     est;
  logic [15:0] dev;
  modport core (output step, output use_est, output last, input est, input dev);
  modport est_side (input step, input use_est, input last, output est, output dev);
endinterface

//--- hw/feedback_link_diag.sv
`timescale 1ns/1ps
`include "link_diag_defines.svh"
module feedback_link_diag
  import link_diag_pkg::*;
#(
  parameter int POS_BITS = 40
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic        LINK_OUTPUT_ENABLE,
  input  wire logic        SYNC_EXT,
  input  wire logic        SYNC_INT,
  input  wire logic        FRAME_DONE,
  input  wire logic        FRAME_ERROR,
  input  wire logic [1:0]  FRAME_KIND,
  input  wire logic [39:0] FRAME_POS,
  input  wire logic [23:0] FRAME_VEL,
  input  wire logic [39:0] SAFE_POS,
  input  wire logic [3:0]  RSSI_IN,
  input  wire logic [2:0]  REMOTE_RSSI_IN,
  input  wire logic [7:0]  SAMPLE_PATTERN_IN,
  input  wire logic [7:0]  CABLE_DELAY_IN,
  output logic             LINK,
  output logic             ESTIMATOR_ON,
  output logic             DEV_THR_ERR,
  output logic             SAFE_MISMATCH,
  output logic             SAMPLING_UNSAFE
);
  initial begin
    if (POS_BITS < 1 || POS_BITS > 40) $error("POS_BITS out of range");
  end

  localparam logic [39:0] POS_MASK = (POS_BITS == 40) ? 40'hFF_FFFF_FFFF : ((40'h1 << POS_BITS) - 40'h1);

  estim_if est ();
  pos_estimator u_est (.CLK_SYS(CLK_SYS), .RST(RST), .e(est));

  function automatic logic [3:0] pop8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) n = n + {3'h0, v[i]};
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [3:0]  errq_r;
  logic [3:0]  rssi_r;
  logic [2:0]  far_rssi_r;
  logic [7:0]  sampling_pattern_register_r;
  logic [7:0]  delay_r;
  logic        link_r;
  logic        qlow_r;
  logic        restart_r;
  logic        est_on_r;
  logic        dev_err_r;
  logic        mism_r;
  logic [39:0] pos_r;
  logic [23:0] vel_r;
  logic [15:0] dev_limit_r;
  logic [7:0]  maxacc_r;
  logic        sync_sel_r;
  logic [7:0]  rdata_r;
  logic [3:0]  errq_nxt;
  logic [3:0]  rssi_nxt;
  logic        link_nxt;
  logic        bad_frame;
  logic        sync_ev;
  logic        frame_step;
  logic        rd_event;
  logic        rd_remote;
  logic [7:0]  rd_mux;
  logic [39:0] safe_diff;
  logic [39:0] safe_masked;
  logic [39:0] pos_new;

  ////////////////////////////////////////////////////////////////////////////
  // per-frame quality
  assign sync_ev    = sync_sel_r ? SYNC_EXT : SYNC_INT;
  assign frame_step = FRAME_DONE & LINK_OUTPUT_ENABLE;
  assign bad_frame  = frame_kind_t'(FRAME_KIND) != FR_OK;
  assign errq_nxt   = FRAME_ERROR ? (errq_r == 4'h0 ? 4'h0 : errq_r - 4'h1)
                                  : (errq_r == `Q_MAX ? errq_r : errq_r + 4'h1);
  assign rssi_nxt   = RSSI_IN > `RSSI_MAX ? `RSSI_MAX : RSSI_IN;
  // link only on full quality and usable strength
  assign link_nxt   = errq_nxt == `Q_MAX && rssi_nxt > `RSSI_BAD;
  assign rd_event   = RD && ADDR == `ADR_EVENT;
  assign rd_remote  = RD && ADDR == `ADR_REMOTE;
  assign safe_masked = SAFE_POS & POS_MASK;
  assign safe_diff  = pos_new >= safe_masked ? pos_new - safe_masked : safe_masked - pos_new;

  always_ff @(posedge CLK_SYS) begin
    if (RST || !LINK_OUTPUT_ENABLE) begin
      errq_r <= 4'h0;
      rssi_r <= 4'h0;
      link_r <= 1'b0;
    end else if (frame_step) begin
      errq_r <= errq_nxt;
      rssi_r <= rssi_nxt;
      // link set once connection is built
      link_r <= link_nxt;
    end
  end

  // event bits: set wins over read-clear
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      qlow_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      // quality low at 14 and below
      qlow_r <= (frame_step && (errq_nxt <= `Q_LOW_LIM || rssi_nxt <= `RSSI_BAD)) ? 1'b1 : (qlow_r & ~rd_event);
      restart_r <= (frame_step && (errq_nxt == 4'h0 || rssi_nxt <= `RSSI_BAD)) ? 1'b1 : (restart_r & ~rd_event);
    end
  end

  // remote strength keeps worst, read resets to 7
  always_ff @(posedge CLK_SYS) begin
    if (RST) far_rssi_r <= `FAR_RSSI_MAX;
    else if (frame_step && REMOTE_RSSI_IN < far_rssi_r) far_rssi_r <= REMOTE_RSSI_IN;
    else if (rd_remote) far_rssi_r <= `FAR_RSSI_MAX;
  end

  // run time and sampling pattern captured
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sampling_pattern_register_r <= 8'h00;
      delay_r <= 8'h00;
    end else if (frame_step) begin
      sampling_pattern_register_r <= SAMPLE_PATTERN_IN;
      delay_r <= CABLE_DELAY_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fast position path
  assign est.step    = frame_step & sync_ev;
  assign est.use_est = bad_frame | FRAME_ERROR;
  assign est.last    = '{pos: FRAME_POS & POS_MASK, vel: FRAME_VEL};
  assign pos_new     = (est.use_est ? est.est.pos : est.last.pos) & POS_MASK;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pos_r     <= 40'h00_0000_0000;
      vel_r     <= 24'h00_0000;
      est_on_r  <= 1'b0;
      dev_err_r <= 1'b0;
      mism_r    <= 1'b0;
    end else if (est.step) begin
      // sample on sync, estimate substituted, right-justified
      pos_r     <= pos_new;
      vel_r     <= est.use_est ? est.est.vel : est.last.vel;
      est_on_r  <= est.use_est;
      dev_err_r <= est.use_est && est.dev > dev_limit_r;
      mism_r    <= safe_diff > `SAFE_DIFF_LIM;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dev_limit_r <= 16'h0000;
      maxacc_r   <= 8'h00;
      sync_sel_r <= 1'b0;
    end else if (WR) begin
      if (ADDR == `ADR_RESOL) maxacc_r <= WDATA;
      if (ADDR == `ADR_CTRL) sync_sel_r <= WDATA[0];
      if (ADDR == `ADR_DEV0 && !est_on_r) dev_limit_r[7:0] <= WDATA;
      if (ADDR == `ADR_DEV1 && !est_on_r) dev_limit_r[15:8] <= WDATA;
    end
  end

  // byte-wise position and speed, deviation readback
  always_comb begin
    rd_mux = 8'h00;
    unique case (ADDR)
      `ADR_QUALITY: rd_mux = {link_r, 3'h0, errq_r};
      `ADR_EVENT:   rd_mux = {6'h00, restart_r, qlow_r};
      `ADR_SAMPLE:  rd_mux = sampling_pattern_register_r;
      `ADR_DELAY:   rd_mux = {rssi_r, delay_r[3:0]};
      8'h0A:        rd_mux = pos_r[7:0];
      8'h0B:        rd_mux = pos_r[15:8];
      8'h0C:        rd_mux = pos_r[23:16];
      8'h0D:        rd_mux = pos_r[31:24];
      8'h0E:        rd_mux = pos_r[39:32];
      `ADR_VEL0:    rd_mux = vel_r[7:0];
      8'h10:        rd_mux = vel_r[15:8];
      8'h11:        rd_mux = vel_r[23:16];
      `ADR_DEV0:    rd_mux = est_on_r ? est.dev[7:0] : dev_limit_r[7:0];
      `ADR_DEV1:    rd_mux = est_on_r ? est.dev[15:8] : dev_limit_r[15:8];
      `ADR_RESOL:   rd_mux = maxacc_r;
      `ADR_CTRL:    rd_mux = {7'h00, sync_sel_r};
      `ADR_REMOTE:  rd_mux = {5'h00, far_rssi_r};
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) rdata_r <= 8'h00;
    else rdata_r <= RD ? rd_mux : 8'h00;
  end

  assign RDATA           = rdata_r;
  assign LINK            = link_r;
  assign ESTIMATOR_ON    = est_on_r;
  assign DEV_THR_ERR     = dev_err_r;
  assign SAFE_MISMATCH   = mism_r;
  assign SAMPLING_UNSAFE = pop8(sampling_pattern_register_r) >= `EDGE_BAD;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // link needs full quality
  a_link_needs_full: assert property (@(posedge CLK_SYS) disable iff (RST)
    LINK |-> errq_r == `Q_MAX && rssi_r > `RSSI_BAD) else $error("link without quality");
  a_link_rise: assert property (@(posedge CLK_SYS) disable iff (RST)
    $rose(LINK) |-> $past(frame_step) && $past(LINK_OUTPUT_ENABLE)) else $error("link rose off frame");
  a_link_off_disable: assert property (@(posedge CLK_SYS) disable iff (RST)
    !LINK_OUTPUT_ENABLE |=> !LINK) else $error("link while disabled");
  a_qlow_set: assert property (@(posedge CLK_SYS) disable iff (RST)
    frame_step && errq_nxt <= `Q_LOW_LIM |=> qlow_r) else $error("quality low missed");
  a_qlow_rssi: assert property (@(posedge CLK_SYS) disable iff (RST)
    frame_step && rssi_nxt <= `RSSI_BAD |=> qlow_r) else $error("quality low on weak signal missed");
  a_restart_set: assert property (@(posedge CLK_SYS) disable iff (RST)
    frame_step && errq_nxt == 4'h0 |=> restart_r && qlow_r) else $error("restart missed");
  a_restart_rssi: assert property (@(posedge CLK_SYS) disable iff (RST)
    frame_step && rssi_nxt <= `RSSI_BAD |=> restart_r) else $error("restart on weak signal missed");

  a_qm_range: assert property (@(posedge CLK_SYS) disable iff (RST)
    frame_step && !FRAME_ERROR && errq_r != `Q_MAX |=> errq_r == $past(errq_r) + 4'h1) else $error("count step");
  a_qm_down: assert property (@(posedge CLK_SYS) disable iff (RST)
    frame_step && FRAME_ERROR && errq_r != 4'h0 |=> errq_r == $past(errq_r) - 4'h1) else $error("count step down");
  a_rssi_range: assert property (@(posedge CLK_SYS) disable iff (RST)
    rssi_r <= `RSSI_MAX) else $error("strength over range");
  a_event_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    !frame_step && !rd_event |=> qlow_r == $past(qlow_r) && restart_r == $past(restart_r))
    else $error("event changed off frame");
  a_run_time: assert property (@(posedge CLK_SYS) disable iff (RST)
    frame_step |=> delay_r == $past(CABLE_DELAY_IN)) else $error("run time not captured");
  a_sample_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
    SAMPLING_UNSAFE |-> sampling_pattern_register_r == 8'hFF) else $error("sampling flag early");

  a_est_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
    est.step && est.use_est |=> ESTIMATOR_ON) else $error("estimator flag missed");
  a_est_off: assert property (@(posedge CLK_SYS) disable iff (RST)
    est.step && !est.use_est |=> !ESTIMATOR_ON) else $error("estimator flag stuck");
  a_dev_nonzero: assert property (@(posedge CLK_SYS) disable iff (RST)
    ESTIMATOR_ON |-> est.dev != 16'h0000) else $error("deviation zero while estimating");
  a_dev_err: assert property (@(posedge CLK_SYS) disable iff (RST)
    est.step && est.use_est && est.dev > dev_limit_r |=> DEV_THR_ERR) else $error("deviation error missed");
  a_pos_justify: assert property (@(posedge CLK_SYS) disable iff (RST)
    (pos_r & ~POS_MASK) == 40'h0) else $error("high position bits set");
  a_pos_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    !est.step |=> pos_r == $past(pos_r)) else $error("position changed off sync");

  a_far_rssi_worse: assert property (@(posedge CLK_SYS) disable iff (RST)
    frame_step && REMOTE_RSSI_IN < far_rssi_r |=> far_rssi_r == $past(REMOTE_RSSI_IN))
    else $error("remote strength not lowered");
  a_remote_strength_value_read: assert property (@(posedge CLK_SYS) disable iff (RST)
    rd_remote && !frame_step |=> far_rssi_r == `FAR_RSSI_MAX) else $error("remote strength not reset");
  a_rd_data: assert property (@(posedge CLK_SYS) disable iff (RST)
    RD && ADDR == `ADR_QUALITY |=> RDATA[3:0] == $past(errq_r)) else $error("quality readback");
  a_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
    !RD |=> RDATA == 8'h00) else $error("read data outside read");

  c_link_up: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(LINK));
  c_est_on: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(ESTIMATOR_ON));
  c_dev_err: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(DEV_THR_ERR));
  c_protocol_restart_event: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(restart_r));
  c_sampling_bad: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(SAMPLING_UNSAFE));
endmodule // feedback_link_diag

//--- hw/link_diag_defines.svh
// Behaviour
// - link flag rises only after link enabled and connection built up
// - low four bits of measured cable run time readable in the run time register
// - edge sampling pattern readable; eight set bits mean not guaranteed
// - received signal strength 0..12 held in run time register
// - quality count 0..15, 15 means no recent errors
// - quality-low event set when quality count at most 14 or strength at most 1
// - protocol-reset event set when count is 0 or strength at most 1
// - link only when count 15 and strength 2..12
// - remote strength 0..7 from encoder side
// - position in five byte registers, speed in three byte registers
// - 40-bit right-justified position, unused high bits read zero
// - fast position checked against safe position
// - fast position sampled on each sync event of the selected source, internal or external, that coincides with a done frame while link output is enabled
// - estimator engages on not-valid character, bad checksum or encoding
// - estimator loads position, speed and nonzero deviation
// - estimator-active high while estimates replace positions
// - deviation error when uncertainty exceeds the deviation limit
`ifndef LINK_DIAG_DEFINES_SVH
`define LINK_DIAG_DEFINES_SVH
`define ADR_QUALITY    8'h03
`define ADR_EVENT      8'h06
`define ADR_SAMPLE     8'h07
`define ADR_DELAY      8'h08
`define ADR_POS0       8'h0A
`define ADR_VEL0       8'h0F
`define ADR_DEV0       8'h12
`define ADR_DEV1       8'h13
`define ADR_RESOL      8'h14
`define ADR_CTRL       8'h15
`define ADR_REMOTE     8'h7C
`define Q_MAX          4'hF
`define Q_LOW_LIM      4'hE
`define RSSI_MAX       4'hC
`define RSSI_BAD       4'h1
`define FAR_RSSI_MAX   3'h7
`define EDGE_BAD       4'h8
`define SAFE_DIFF_LIM  40'h00_0000_0100
`endif

//--- hw/link_diag_pkg.sv
package link_diag_pkg;
  typedef enum logic [1:0] {
    FR_OK,
    FR_NOT_VALID,
    FR_BAD_CRC,
    FR_BAD_CODE
  } frame_kind_t;
  typedef struct packed {
    logic [39:0] pos;
    logic [23:0] vel;
  } sample_t;
endpackage

//--- hw/pos_estimator.sv
`timescale 1ns/1ps
`include "link_diag_defines.svh"
module pos_estimator
  import link_diag_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  estim_if.est_side e
);
  logic [15:0] dev_r;
  logic [15:0] dev_nxt;
  sample_t     est_r;
  sample_t     est_nxt;
  logic [39:0] ext_vel;

  assign ext_vel = {{16{e.last.vel[23]}}, e.last.vel};
  // uncertainty grows each estimated frame, cleared on good frame
  assign dev_nxt = !e.use_est ? 16'h0000 : (dev_r == 16'hFFFF ? dev_r : dev_r + 16'h0001);
  assign est_nxt = e.use_est ? '{pos: est_r.pos + ext_vel, vel: est_r.vel}
                             : '{pos: e.last.pos + ext_vel, vel: e.last.vel};

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dev_r <= 16'h0000;
      est_r <= '0;
    end else if (e.step) begin
      dev_r <= dev_nxt;
      est_r <= est_nxt;
    end
  end
  assign e.est = e.use_est ? est_r : e.last;
  assign e.dev = dev_r;
endmodule // pos_estimator

//--- tb/encoder_frame_source.sv
`timescale 1ns/1ps
module encoder_frame_source
  import link_diag_pkg::*;
(
  input  wire logic        clk,
  output logic             done,
  output logic             err,
  output logic [1:0]       kind,
  output logic [39:0]      pos,
  output logic [23:0]      vel,
  output logic [1:0]       sync,
  output logic [3:0]       rssi,
  output logic [2:0]       remote
);
  initial begin
    done = 1'h0;
    err = 1'h0;
    kind = 2'h0;
    pos = 40'h0;
    vel = 24'h0;
    sync = 2'h0;
    rssi = 4'h0;
    remote = 3'h7;
  end
  //////////////////////////////////////////////////////////////
  // faulty frames on request
  task automatic send(input frame_kind_t k, input logic e, input logic [1:0] s, input logic [39:0] p,
                      input logic [23:0] v, input logic [3:0] r, input logic [2:0] m);
    @(posedge clk);
    done <= 1'h1;
    err <= e;
    kind <= k;
    pos <= p;
    vel <= v;
    sync <= s;
    rssi <= r;
    remote <= m;
    @(posedge clk);
    done <= 1'h0;
    err <= ~e;
    kind <= ~k;
    pos <= ~p;
    vel <= ~v;
    sync <= 2'h0;
  endtask
endmodule // encoder_frame_source

//--- tb/feedback_link_diag_test.sv
`timescale 1ns/1ps
`include "link_diag_defines.svh"
module feedback_link_diag_test;
  import link_diag_pkg::*;
  localparam int PB = 24;
  logic        CLK_SYS = 1'h0;
  logic        RST = 1'h1;
  logic [7:0]  ADDR = 8'h00;
  logic [7:0]  WDATA = 8'h00;
  logic        WR = 1'h0;
  logic        RD = 1'h0;
  logic        LINK_OUTPUT_ENABLE = 1'h0;
  logic [39:0] SAFE_POS = 40'h0;
  logic [7:0]  SAMPLE_PATTERN_IN = 8'h01;
  logic [7:0]  CABLE_DELAY_IN = 8'h35;
  wire         FRAME_DONE, FRAME_ERROR, SYNC_EXT, SYNC_INT;
  wire  [1:0]  FRAME_KIND;
  wire  [39:0] FRAME_POS;
  wire  [23:0] FRAME_VEL;
  wire  [3:0]  RSSI_IN;
  wire  [2:0]  REMOTE_RSSI_IN;
  logic [7:0]  RDATA;
  logic        LINK, ESTIMATOR_ON, DEV_THR_ERR, SAFE_MISMATCH, SAMPLING_UNSAFE;
  int          fails = 0;
  int          tests_run = 0;
  always #2 CLK_SYS = ~CLK_SYS;
  feedback_link_diag #(.POS_BITS(PB)) i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .LINK_OUTPUT_ENABLE(LINK_OUTPUT_ENABLE), .SYNC_EXT(SYNC_EXT),
    .SYNC_INT(SYNC_INT), .FRAME_DONE(FRAME_DONE), .FRAME_ERROR(FRAME_ERROR), .FRAME_KIND(FRAME_KIND),
    .FRAME_POS(FRAME_POS), .FRAME_VEL(FRAME_VEL), .SAFE_POS(SAFE_POS), .RSSI_IN(RSSI_IN),
    .REMOTE_RSSI_IN(REMOTE_RSSI_IN), .SAMPLE_PATTERN_IN(SAMPLE_PATTERN_IN), .CABLE_DELAY_IN(CABLE_DELAY_IN),
    .LINK(LINK), .ESTIMATOR_ON(ESTIMATOR_ON), .DEV_THR_ERR(DEV_THR_ERR), .SAFE_MISMATCH(SAFE_MISMATCH),
    .SAMPLING_UNSAFE(SAMPLING_UNSAFE));
  encoder_frame_source i_enc (.clk(CLK_SYS), .done(FRAME_DONE), .err(FRAME_ERROR), .kind(FRAME_KIND),
    .pos(FRAME_POS), .vel(FRAME_VEL), .sync({SYNC_EXT, SYNC_INT}), .rssi(RSSI_IN), .remote(REMOTE_RSSI_IN));
  //////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge CLK_SYS);
    WR <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge CLK_SYS);
    RD <= 1'h0;
    @(negedge CLK_SYS);
    d = RDATA;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask
  task automatic flag(input string what, input logic seen, input logic exp);
    @(negedge CLK_SYS);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic frames(input int n, input logic e, input logic [3:0] r);
    repeat (n) i_enc.send(FR_OK, e, 2'h0, 40'h0, 24'h0, r, 3'h5);
    @(negedge CLK_SYS);
  endtask
  task automatic sync_frame(input frame_kind_t k, input logic [1:0] s, input logic [39:0] p, input logic [23:0] v);
    i_enc.send(k, 1'h0, s, p, v, 4'hC, 3'h5);
    @(negedge CLK_SYS);
  endtask
  task automatic pos_chk(input logic [39:0] p, input logic [23:0] v);
    for (int i = 0; i < 5; i++) rchk("pos byte", `ADR_POS0 + 8'(i), p[8*i +: 8]);
    for (int i = 0; i < 3; i++) rchk("vel byte", `ADR_VEL0 + 8'(i), v[8*i +: 8]);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    fails++;
    conclude();
  end
  initial begin
    logic [7:0] d0, d1;
    repeat (4) @(posedge CLK_SYS);
    RST <= 1'h0;
    rchk("remote after reset", `ADR_REMOTE, 8'h07);
    rchk("unmapped", 8'h50, 8'h00);
    frames(1, 1'h0, 4'hC);
    rchk("quality disabled", `ADR_QUALITY, 8'h00);
    LINK_OUTPUT_ENABLE <= 1'h1;
    frames(14, 1'h0, 4'hC);
    rchk("quality 14", `ADR_QUALITY, 8'h0E);
    frames(1, 1'h0, 4'hC);
    rchk("quality 15", `ADR_QUALITY, 8'h8F);
    flag("link up", LINK, 1'h1);
    rchk("delay reg", `ADR_DELAY, 8'hC5);
    rchk("remote 5", `ADR_REMOTE, 8'h05);
    rchk("remote reread", `ADR_REMOTE, 8'h07);
    rd(`ADR_EVENT, d0);
    frames(1, 1'h0, 4'hC);
    rchk("event clean", `ADR_EVENT, 8'h00);
    frames(1, 1'h1, 4'hC);
    rchk("quality drop", `ADR_QUALITY, 8'h0E);
    rchk("event low", `ADR_EVENT, 8'h01);
    frames(13, 1'h1, 4'hC);
    rchk("quality 1", `ADR_QUALITY, 8'h01);
    rchk("event low 1", `ADR_EVENT, 8'h01);
    frames(1, 1'h1, 4'hC);
    rchk("event broken", `ADR_EVENT, 8'h03);
    flag("link broken", LINK, 1'h0);
    frames(15, 1'h0, 4'hC);
    rd(`ADR_EVENT, d0);
    frames(1, 1'h0, 4'h1);
    rchk("event weak", `ADR_EVENT, 8'h03);
    flag("link weak", LINK, 1'h0);
    frames(1, 1'h0, 4'h2);
    rchk("event rssi 2", `ADR_EVENT, 8'h00);
    flag("link rssi 2", LINK, 1'h1);
    i_enc.send(FR_OK, 1'h0, 2'h0, 40'h0, 24'h0, 4'hC, 3'h3);
    rchk("remote 3", `ADR_REMOTE, 8'h03);
    SAMPLE_PATTERN_IN <= 8'hFE;
    frames(1, 1'h0, 4'hC);
    rchk("pattern", `ADR_SAMPLE, 8'hFE);
    flag("seven sampling_pattern_register", SAMPLING_UNSAFE, 1'h0);
    SAMPLE_PATTERN_IN <= 8'hFF;
    frames(1, 1'h0, 4'hC);
    flag("eight sampling_pattern_register", SAMPLING_UNSAFE, 1'h1);
    wr(`ADR_CTRL, 8'h00);
    sync_frame(FR_OK, 2'h1, 40'hAB_CDEF_1234, 24'h56_789A);
    pos_chk(40'hAB_CDEF_1234 & ((40'h1 << PB) - 40'h1), 24'h56_789A);
    sync_frame(FR_OK, 2'h0, 40'h00_0011_2233, 24'h00_0001);
    pos_chk(40'h00_00EF_1234, 24'h56_789A);
    wr(`ADR_CTRL, 8'h01);
    sync_frame(FR_OK, 2'h1, 40'h00_0011_2233, 24'h00_0001);
    pos_chk(40'h00_00EF_1234, 24'h56_789A);
    SAFE_POS <= 40'h00_0011_2233;
    sync_frame(FR_OK, 2'h2, 40'h00_0011_2233, 24'h00_0002);
    pos_chk(40'h00_0011_2233, 24'h00_0002);
    flag("safe match", SAFE_MISMATCH, 1'h0);
    SAFE_POS <= 40'h00_0011_2233 + (`SAFE_DIFF_LIM << 4);
    sync_frame(FR_OK, 2'h2, 40'h00_0011_2233, 24'h00_0002);
    flag("safe mismatch", SAFE_MISMATCH, 1'h1);
    wr(`ADR_DEV0, 8'hFF);
    wr(`ADR_DEV1, 8'hFF);
    // each faulty frame kind engages the estimator, deviation nonzero and below the limit
    for (int k = 1; k < 4; k++) begin
      sync_frame(frame_kind_t'(k), 2'h2, 40'h00_0011_2233, 24'h00_0002);
      flag("estimator on", ESTIMATOR_ON, 1'h1);
      flag("below limit", DEV_THR_ERR, 1'h0);
      rd(`ADR_DEV0, d0);
      rd(`ADR_DEV1, d1);
      check("deviation nonzero", {7'h00, |{d0, d1}}, 8'h01);
    end
    sync_frame(FR_OK, 2'h2, 40'h00_0011_2233, 24'h00_0002);
    flag("estimator off", ESTIMATOR_ON, 1'h0);
    wr(`ADR_DEV0, 8'h00);
    wr(`ADR_DEV1, 8'h00);
    sync_frame(FR_NOT_VALID, 2'h2, 40'h00_0011_2233, 24'h00_0002);
    flag("at limit", DEV_THR_ERR, 1'h0);
    sync_frame(FR_NOT_VALID, 2'h2, 40'h00_0011_2233, 24'h00_0002);
    flag("above limit", DEV_THR_ERR, 1'h1);
    LINK_OUTPUT_ENABLE <= 1'h0;
    repeat (2) @(posedge CLK_SYS);
    rchk("quality cleared", `ADR_QUALITY, 8'h00);
    conclude();
  end
endmodule // feedback_link_diag_test
